// *** src/cgs_regs.sv ***
// The address map and register access over APB were decided locally.
`timescale 1ns/1ns
// What this block does
// - Status bits 7:6 report active mode: self, FEI, FBE, FEE
// - Mode status follows mode select only after two-stage synchronisation
// - Status bit 5 shows selected reference: 0 external, 1 crystal
// - Sticky lock-lost flag set on unexpected lock loss until cleared
// - Lock bit shows lock, forced 0 in off, self and bypass modes
// - Sticky clock-lost flag set on clock loss until cleared
// - External-reference bit is 1 only while reference is stable
// - Interrupt flag set while request pending, cleared by reset
// - Flag clears only after status read with flag set then write 1
// - New event during clear sequence restarts it; flag stays set
// - Writing 0 to the interrupt flag has no effect
// - Oscillator stable when error steady two samples and clock active
// - Oscillator stable bit cleared on entering off state
// - Leaving off with select X1 waits for oscillator stable
// - Filter writable only when mode select is self-clocked
// - 12-bit filter split upper 4 / lower 8; upper write loads all
// - Upper write discarded while previous latch sequence in progress
// - Filter registers read back the current filter value
// - Lock loss gives interrupt if enable 0, reset request if 1
// - Clock loss gives interrupt if enable 0, reset request if 1
module cgs_regs
  import cgs_pkg::*;
#(
  parameter int LATCH_CYCLES = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Generator side, asynchronous pins
  input wire cgs_gen_in_t gen_in,
  input wire logic [11:0] loop_error,
  input wire logic [11:0] loop_filter_next,
  input wire logic loop_filter_load,
  // Generator outputs
  output logic [1:0] mode_select_field,
  output logic [11:0] loop_filter_value,
  output cgs_req_t req
);
  logic apb_access;
  logic apb_wr;
  logic apb_rd;
  logic mapped;
  logic [1:0] mode_status;
  logic lock_lost_flag;
  logic clock_lost_flag;
  logic clockgen_irq_flag;
  logic oscillator_stable_bit;
  logic lock_lost_reset_enable;
  logic clock_lost_reset_enable;
  logic [7:0] lower_stage;
  // Wide enough for any latch window the instance asks for
  localparam int BUSY_W = $clog2(LATCH_CYCLES + 1);
  logic [BUSY_W-1:0] latch_busy;
  logic clear_armed;
  logic [11:0] prev_error;
  logic steady_once;
  logic off_prev;
  logic waiting_stable;
  logic [1:0] mode_sync1;
  logic [1:0] mode_sync2;
  logic [$bits(cgs_gen_in_t)-1:0] in_s1;
  cgs_gen_in_t gin;
  logic [11:0] err_s1;
  logic [11:0] err_s2;
  logic [11:0] err_diff;
  logic irq_event;
  logic upper_wr;
  logic upper_ok;
  logic [7:0] status_main;

  assign apb_access = psel & penable;
  assign apb_wr = apb_access & pwrite;
  assign apb_rd = apb_access & ~pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == OFS_STATUS_MAIN) || (paddr == OFS_STATUS_OSC) ||
                  (paddr == OFS_FILTER_UPPER) ||
                  (paddr == OFS_FILTER_LOWER) || (paddr == OFS_CONTROL);
  assign pslverr = apb_access & ~mapped;

  // Generator status pins and loop error pass two flops before use; the filter load pins are used directly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_s1 <= '0;
      gin <= '0;
      err_s1 <= 12'h000;
      err_s2 <= 12'h000;
    end else begin
      in_s1 <= gen_in;
      gin <= in_s1;
      err_s1 <= loop_error;
      err_s2 <= err_s1;
    end
  end

  // Control: mode select and reset enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_select_field <= MODE_RESET;
      lock_lost_reset_enable <= 1'b0;
      clock_lost_reset_enable <= 1'b0;
    end else if (apb_wr && paddr == OFS_CONTROL) begin
      mode_select_field <= pwdata[MODE_SEL_LO +: 2];
      lock_lost_reset_enable <= pwdata[LOCK_LOST_RE_BIT];
      clock_lost_reset_enable <= pwdata[CLOCK_LOST_RE_BIT];
    end
  end

  // Mode status lags the select by three flops (two sync, one status); waits on stability
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sync1 <= MODE_RESET;
      mode_sync2 <= MODE_RESET;
      mode_status <= MODE_RESET;
      off_prev <= 1'b0;
      waiting_stable <= 1'b0;
    end else begin
      mode_sync1 <= mode_select_field;
      mode_sync2 <= mode_sync1;
      off_prev <= gin.off_state;
      if (off_prev && !gin.off_state && mode_sync2[0]) begin
        waiting_stable <= 1'b1;
        mode_status <= CGS_SELF;
      end else if (waiting_stable) begin
        if (oscillator_stable_bit) begin
          waiting_stable <= 1'b0;
          mode_status <= mode_sync2;
        end
      end else if (mode_sync2 == CGS_FBE && !gin.ext_ok) begin
        mode_status <= CGS_SELF; // Bypass needs a good reference
      end else begin
        mode_status <= mode_sync2;
      end
    end
  end

  // Oscillator stable: error steady over two consecutive samples
  assign err_diff = (err_s2 >= prev_error) ? err_s2 - prev_error :
                    prev_error - err_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_error <= 12'h000;
      steady_once <= 1'b0;
      oscillator_stable_bit <= 1'b0;
    end else begin
      prev_error <= err_s2;
      if (gin.off_state) begin
        steady_once <= 1'b0;
        oscillator_stable_bit <= 1'b0;
      end else begin
        steady_once <= err_diff <= UNLOCK_THRESH;
        oscillator_stable_bit <= steady_once &&
          (err_diff <= UNLOCK_THRESH) && gin.osc_active;
      end
    end
  end

  // Sticky loss flags; set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_lost_flag <= 1'b0;
      clock_lost_flag <= 1'b0;
    end else begin
      if (gin.lock_lost_ev)
        lock_lost_flag <= 1'b1;
      else if (apb_wr && paddr == OFS_STATUS_MAIN &&
               pwdata[LOCK_LOST_BIT])
        lock_lost_flag <= 1'b0;
      if (gin.clock_lost_ev)
        clock_lost_flag <= 1'b1;
      else if (apb_wr && paddr == OFS_STATUS_MAIN &&
               pwdata[CLOCK_LOST_BIT])
        clock_lost_flag <= 1'b0;
    end
  end

  assign irq_event = (gin.lock_lost_ev & ~lock_lost_reset_enable) |
                     (gin.clock_lost_ev & ~clock_lost_reset_enable);

  // Interrupt flag with read-then-write-1 clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clockgen_irq_flag <= 1'b0;
      clear_armed <= 1'b0;
    end else if (irq_event) begin
      clockgen_irq_flag <= 1'b1;
      clear_armed <= 1'b0;
    end else if (apb_rd && paddr == OFS_STATUS_MAIN && clockgen_irq_flag) begin
      clear_armed <= 1'b1;
    end else if (apb_wr && paddr == OFS_STATUS_MAIN && clear_armed &&
                 pwdata[IRQ_FLAG_BIT]) begin
      clockgen_irq_flag <= 1'b0;
      clear_armed <= 1'b0;
    end
    // A write of 0 falls through all branches and changes nothing
  end

  always_comb begin
    req.irq = clockgen_irq_flag;
    req.reset_req = (lock_lost_flag & lock_lost_reset_enable) |
                    (clock_lost_flag & clock_lost_reset_enable);
  end

  // Filter: lower is staged, upper write commits all twelve bits
  assign upper_wr = apb_wr && paddr == OFS_FILTER_UPPER;
  assign upper_ok = upper_wr && mode_select_field == CGS_SELF &&
                    latch_busy == '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_stage <= 8'h00;
    end else if (apb_wr && paddr == OFS_FILTER_LOWER &&
                 mode_select_field == CGS_SELF) begin
      lower_stage <= pwdata[7:0];
    end
  end

  // Latch sequence models the hand-off to the oscillator domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_filter_value <= FILTER_RESET;
      latch_busy <= '0;
    end else if (upper_ok) begin
      loop_filter_value <= {pwdata[3:0], lower_stage};
      latch_busy <= BUSY_W'(LATCH_CYCLES);
    end else begin
      if (latch_busy != '0)
        latch_busy <= latch_busy - BUSY_W'(1);
      if (loop_filter_load && mode_select_field != CGS_SELF)
        loop_filter_value <= loop_filter_next;
    end
  end

  always_comb begin
    status_main = 8'h00;
    status_main[MODE_ST_HI:MODE_ST_LO] = mode_status;
    status_main[REF_SEL_BIT] = gin.ref_crystal;
    status_main[LOCK_LOST_BIT] = lock_lost_flag;
    status_main[LOCK_BIT] = gin.locked && !gin.off_state &&
      (mode_status == CGS_FEI || mode_status == CGS_FEE);
    status_main[CLOCK_LOST_BIT] = clock_lost_flag;
    status_main[EXT_OK_BIT] = gin.ext_ok;
    status_main[IRQ_FLAG_BIT] = clockgen_irq_flag;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_STATUS_MAIN: prdata <= {24'h000000, status_main};
        OFS_STATUS_OSC: prdata <= {31'h0, oscillator_stable_bit};
        OFS_FILTER_UPPER: prdata <= {28'h0, loop_filter_value[11:8]};
        OFS_FILTER_LOWER: prdata <= {24'h0, loop_filter_value[7:0]};
        OFS_CONTROL: prdata <= {26'h0, clock_lost_reset_enable,
                                lock_lost_reset_enable, 2'h0,
                                mode_select_field};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  irq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && paddr == OFS_STATUS_MAIN && pwdata[IRQ_FLAG_BIT] &&
     !clear_armed && !irq_event && clockgen_irq_flag) |=> clockgen_irq_flag)
    else $error("irq flag cleared without prior read");
  irq_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && paddr == OFS_STATUS_MAIN && !pwdata[IRQ_FLAG_BIT] &&
     clockgen_irq_flag) |=> clockgen_irq_flag)
    else $error("zero write changed irq flag");
  irq_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_event |=> clockgen_irq_flag && !clear_armed)
    else $error("event did not set flag");
  lock_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    gin.lock_lost_ev |=> lock_lost_flag)
    else $error("lock lost flag not set");
  clk_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
    gin.clock_lost_ev |=> clock_lost_flag)
    else $error("clock lost flag not set");
  filt_guard_a: assert property (@(posedge pclk) disable iff (!presetn)
    (upper_wr && mode_select_field != CGS_SELF && !loop_filter_load) |=>
    $stable(loop_filter_value))
    else $error("filter changed outside self mode");
  filt_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    upper_ok |=> !upper_ok)
    else $error("second latch accepted while busy");
  lock_force_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_status == CGS_SELF || mode_status == CGS_FBE) |->
    !status_main[LOCK_BIT])
    else $error("lock shown in unlocked mode");
  osc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    gin.off_state |=> !oscillator_stable_bit)
    else $error("stable bit not cleared in off");
  mode_lag_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(mode_select_field) |-> ##1 mode_sync2 == $past(mode_sync2))
    else $error("mode status not delayed");
  rd_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == OFS_STATUS_MAIN) |=>
    prdata[REF_SEL_BIT] == $past(gin.ref_crystal))
    else $error("reference bit read wrong");
  rd_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == OFS_STATUS_MAIN) |=>
    prdata[EXT_OK_BIT] == $past(gin.ext_ok))
    else $error("external ok bit read wrong");
  rd_filt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && paddr == OFS_FILTER_LOWER) |=>
    prdata[7:0] == $past(loop_filter_value[7:0]))
    else $error("filter lower read wrong");
  filt_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    upper_ok |=>
    loop_filter_value == {$past(pwdata[3:0]), $past(lower_stage)})
    else $error("filter commit value wrong");
  stage_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (apb_wr && paddr == OFS_FILTER_LOWER && mode_select_field != CGS_SELF)
    |=> $stable(lower_stage))
    else $error("lower stage written outside self mode");
  lock_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gin.lock_lost_ev && !lock_lost_reset_enable) |=> req.irq)
    else $error("lock loss gave no interrupt");
  lock_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gin.lock_lost_ev && lock_lost_reset_enable) |=> req.reset_req)
    else $error("lock loss gave no reset request");
  clk_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gin.clock_lost_ev && !clock_lost_reset_enable) |=> req.irq)
    else $error("clock loss gave no interrupt");
  clk_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    (gin.clock_lost_ev && clock_lost_reset_enable) |=> req.reset_req)
    else $error("clock loss gave no reset request");
  irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (clockgen_irq_flag && !(apb_wr && paddr == OFS_STATUS_MAIN)) |=>
    clockgen_irq_flag)
    else $error("irq flag dropped without a write");
  lock_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (lock_lost_flag && !(apb_wr && paddr == OFS_STATUS_MAIN &&
     pwdata[LOCK_LOST_BIT])) |=> lock_lost_flag)
    else $error("lock lost flag dropped");
  osc_need_a: assert property (@(posedge pclk) disable iff (!presetn)
    !gin.osc_active |=> !oscillator_stable_bit)
    else $error("stable shown with static oscillator");
  wait_self_a: assert property (@(posedge pclk) disable iff (!presetn)
    waiting_stable |-> mode_status == CGS_SELF)
    else $error("mode left self before stable");

  clr_seq_c: cover property (@(posedge pclk) disable iff (!presetn)
    clear_armed ##[1:20] !clockgen_irq_flag);
  filt_load_c: cover property (@(posedge pclk) disable iff (!presetn)
    upper_ok);
  rst_req_c: cover property (@(posedge pclk) disable iff (!presetn)
    req.reset_req);
  wait_c: cover property (@(posedge pclk) disable iff (!presetn)
    waiting_stable ##1 !waiting_stable);
  irq_restart_c: cover property (@(posedge pclk) disable iff (!presetn)
    clear_armed ##1 irq_event);
endmodule // cgs_regs

// *** src/cgs_pkg.sv ***
package cgs_pkg;
  // Register word offsets on the APB (byte addresses)
  localparam logic [7:0] OFS_STATUS_MAIN = 8'h00;
  localparam logic [7:0] OFS_STATUS_OSC = 8'h04;
  localparam logic [7:0] OFS_FILTER_UPPER = 8'h08;
  localparam logic [7:0] OFS_FILTER_LOWER = 8'h0C;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  // Status main and status osc field positions
  localparam int MODE_ST_HI = 7;
  localparam int MODE_ST_LO = 6;
  localparam int REF_SEL_BIT = 5;
  localparam int LOCK_LOST_BIT = 4;
  localparam int LOCK_BIT = 3;
  localparam int CLOCK_LOST_BIT = 2;
  localparam int EXT_OK_BIT = 1;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int OSC_STABLE_BIT = 0;
  // Control register positions (mode select, reset enables)
  localparam int MODE_SEL_LO = 0;
  localparam int LOCK_LOST_RE_BIT = 4;
  localparam int CLOCK_LOST_RE_BIT = 5;
  // Reset values, sizes and the unlock threshold
  localparam logic [11:0] FILTER_RESET = 12'h000;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] SYNC_STAGES = 2'h2;
  localparam int FILTER_W = 12;
  localparam logic [11:0] UNLOCK_THRESH = 12'h010;
  typedef enum logic [1:0] {
    CGS_SELF, CGS_FEI, CGS_FBE, CGS_FEE
  } cgs_mode_t;
  typedef struct packed {
    logic lock_lost_ev;
    logic clock_lost_ev;
    logic locked;
    logic ext_ok;
    logic ref_crystal;
    logic osc_active;
    logic off_state;
  } cgs_gen_in_t;
  typedef struct packed {
    logic irq;
    logic reset_req;
  } cgs_req_t;
endpackage

// *** dv/tb_top.sv ***
`timescale 1ns/1ns
module tb_top
  import cgs_pkg::*;
;
  // Clock and reset
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  // APB master
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Generator side
  cgs_gen_in_t gen_in = '0;
  logic [11:0] loop_error = 12'h000;
  logic [11:0] loop_filter_next = 12'h000;
  logic loop_filter_load = 1'b0;
  logic [1:0] mode_select_field;
  logic [11:0] loop_filter_value;
  cgs_req_t req;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic er;

  // Long latch window so that two back-to-back upper writes collide
  cgs_regs #(.LATCH_CYCLES(8)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gen_in(gen_in), .loop_error(loop_error),
    .loop_filter_next(loop_filter_next), .loop_filter_load(loop_filter_load),
    .mode_select_field(mode_select_field),
    .loop_filter_value(loop_filter_value), .req(req));

  initial begin
    forever #10 pclk = ~pclk;
  end

  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      $display("Error %0t: run did not finish", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string s);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string s);
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, a, 32'h0);
      if ((rd & m) === e) break;
    end
    chk(rd & m, e, s);
  endtask

  task automatic ctl(input logic [1:0] m, input logic lo, input logic lc);
    apb(1'b1, OFS_CONTROL, {26'h0, lc, lo, 2'b00, m});
  endtask

  task automatic pulse_event(input logic lock_ev);
    @(posedge pclk);
    if (lock_ev) gen_in.lock_lost_ev <= 1'b1;
    else gen_in.clock_lost_ev <= 1'b1;
    @(posedge pclk);
    gen_in.lock_lost_ev <= 1'b0;
    gen_in.clock_lost_ev <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask

  task automatic t_reset();
    apb(1'b0, OFS_STATUS_MAIN, 32'h0);
    chk(rd, 32'h0, "status after reset");
    apb(1'b0, OFS_FILTER_UPPER, 32'h0);
    chk(rd, 32'h0, "filter upper after reset");
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[0], er}, 2'b01, "unmapped read");
  endtask

  task automatic t_mode();
    logic [1:0] ms[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    gen_in.ext_ok <= 1'b1;
    gen_in.ref_crystal <= 1'b1;
    gen_in.locked <= 1'b1;
    foreach (ms[i]) begin
      ctl(ms[i], 1'b0, 1'b0);
      @(negedge pclk);
      chk(mode_select_field, ms[i], "mode select out");
      poll(OFS_STATUS_MAIN, 32'hC0, {ms[i], 6'h0}, "mode status");
      chk(rd[5:1], {1'b1, 1'b0, ms[i][0], 1'b0, 1'b1}, "ref lock ext");
    end
    gen_in.ext_ok <= 1'b0;
    gen_in.ref_crystal <= 1'b0;
    poll(OFS_STATUS_MAIN, 32'h22, 32'h0, "ext and ref low");
  endtask

  task automatic t_filter();
    apb(1'b1, OFS_FILTER_LOWER, 32'h5A);
    apb(1'b0, OFS_FILTER_UPPER, 32'h0);
    chk(rd, 32'h0, "lower alone staged");
    apb(1'b1, OFS_FILTER_UPPER, 32'h7);
    apb(1'b1, OFS_FILTER_UPPER, 32'h1);
    @(negedge pclk);
    chk(loop_filter_value, 12'h75A, "second upper dropped");
    apb(1'b0, OFS_FILTER_LOWER, 32'h0);
    chk(rd, 32'h5A, "lower readback");
    repeat (10) @(posedge pclk);
    apb(1'b1, OFS_FILTER_UPPER, 32'h3);
    @(negedge pclk);
    chk(loop_filter_value, 12'h35A, "upper after window");
    ctl(2'h1, 1'b0, 1'b0);
    apb(1'b1, OFS_FILTER_UPPER, 32'hF);
    @(negedge pclk);
    chk(loop_filter_value, 12'h35A, "write outside self");
    @(posedge pclk);
    loop_filter_next <= 12'hABC;
    loop_filter_load <= 1'b1;
    @(posedge pclk);
    loop_filter_load <= 1'b0;
    poll(OFS_FILTER_UPPER, 32'hF, 32'hA, "loop value upper");
    apb(1'b0, OFS_FILTER_LOWER, 32'h0);
    chk(rd, 32'hBC, "loop value lower");
  endtask

  task automatic t_irq();
    ctl(2'h0, 1'b0, 1'b1);
    pulse_event(1'b1);
    apb(1'b1, OFS_STATUS_MAIN, 32'h0);
    apb(1'b0, OFS_STATUS_MAIN, 32'h0);
    chk({rd[4], rd[0], req}, 4'b1110, "lock loss irq");
    pulse_event(1'b1);
    apb(1'b1, OFS_STATUS_MAIN, 32'h11);
    @(negedge pclk);
    chk({req.irq}, 1'b1, "event restarts clear");
    apb(1'b0, OFS_STATUS_MAIN, 32'h0);
    apb(1'b1, OFS_STATUS_MAIN, 32'h01);
    apb(1'b0, OFS_STATUS_MAIN, 32'h0);
    chk({rd[4], rd[0], req}, 4'b0000, "flag cleared");
    pulse_event(1'b0);
    apb(1'b0, OFS_STATUS_MAIN, 32'h0);
    chk({rd[2], rd[0], req}, 4'b1001, "clock loss reset");
    apb(1'b1, OFS_STATUS_MAIN, 32'h04);
    @(negedge pclk);
    chk({req}, 2'b00, "clock loss cleared");
  endtask

  task automatic t_osc();
    gen_in.osc_active <= 1'b1;
    loop_error <= 12'h123;
    poll(OFS_STATUS_OSC, 32'h1, 32'h1, "osc stable");
    ctl(2'h1, 1'b0, 1'b0);
    gen_in.off_state <= 1'b1;
    poll(OFS_STATUS_OSC, 32'h1, 32'h0, "osc cleared in off");
    gen_in.off_state <= 1'b0;
    poll(OFS_STATUS_MAIN, 32'hC0, 32'h40, "mode after off");
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mode();
    t_filter();
    t_irq();
    t_osc();
    wrap_up();
  end
endmodule // tb_top
